// >>> plane_datapath.sv
// How it works
// RL1: Index port selects register, upper bits zero.
// RL2: Indices 00-04 pick the five registers.
// RL3: Fill value bit spread over plane byte.
// RL4: Fill enable picks fill or host data.
// RL5: Compare read flags bits matching all planes.
// RL6: Two-bit select: pass, AND, OR, XOR.
// RL7: Rotate happens before the logical combine.
// RL8: Latch-copy writes are never combined.
// RL9: Mode 0 right-rotates host data by count.
// RL10: Plane choice bits pick read plane.
// RL11: Plane choice ignored for compare reads.
// RL12: Odd/even pairs planes 0/1 and 2/3.
// RL13: Read type bit picks compare or plane.
// RL14: Every memory read reloads the latches.
// RL15: Mode 0 writes rotated data unless filled.
// RL16: Data port reads show selected register.
`timescale 1ns/1ps
`default_nettype none
module plane_datapath (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [15:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   input wire logic [1:0] write_mode,
   input wire logic read_type,
   input wire logic odd_even,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_rd,
   input wire logic mem_a0,
   input wire plane_path_pkg::plane_bytes_t mem_rdata,
   output plane_path_pkg::plane_bytes_t plane_wdata,
   output logic plane_we,
   output logic [7:0] host_rdata,
   output logic host_rvalid
);
   import plane_path_pkg::*;

   logic [INDEX_W-1:0] index_q;
   logic [3:0] fill_value_q;
   logic [3:0] fill_enable_q;
   logic [3:0] match_value_q;
   logic [4:0] combine_shift_q;
   logic [1:0] plane_choice_q;
   plane_bytes_t latch_q;
   plane_bytes_t plane_wdata_q;
   logic plane_we_q;
   logic [7:0] host_rdata_q;
   logic host_rvalid_q;
   logic [7:0] io_rdata_q;
   logic [7:0] io_rdata_d;
   logic [7:0] host_rdata_d;
   logic [7:0] match_bits;
   logic [1:0] read_plane;
   logic idx_wr;
   logic data_wr;

   plane_shape_if sh ();

   // Address decode
   function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] port);
      port_hit = (addr == port);
   endfunction

   assign idx_wr = io_wr && port_hit(io_addr, IO_INDEX_PORT);
   assign data_wr = io_wr && port_hit(io_addr, IO_DATA_PORT);

   // Index register
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         index_q <= RESET_INDEX[INDEX_W-1:0];
      end else if (idx_wr) begin
         index_q <= io_wdata[INDEX_LSB +: INDEX_W]; // [RL1]
      end
   end

   // Indexed registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fill_value_q <= RESET_REG[3:0];
      end else if (data_wr && index_q == IDX_FILL_VALUE) begin // [RL2]
         fill_value_q <= io_wdata[PLANE_FIELD_LSB +: PLANE_FIELD_W]; // [RL3]
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fill_enable_q <= RESET_REG[3:0];
      end else if (data_wr && index_q == IDX_FILL_ENABLE) begin // [RL2]
         fill_enable_q <= io_wdata[PLANE_FIELD_LSB +: PLANE_FIELD_W]; // [RL4]
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         match_value_q <= RESET_REG[3:0];
      end else if (data_wr && index_q == IDX_MATCH_VALUE) begin // [RL2]
         match_value_q <= io_wdata[PLANE_FIELD_LSB +: PLANE_FIELD_W]; // [RL5]
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         combine_shift_q <= RESET_REG[4:0];
      end else if (data_wr && index_q == IDX_COMBINE_SHIFT) begin // [RL2]
         combine_shift_q <= io_wdata[ROT_LSB +: (ROT_W + FUNC_W)]; // [RL6] [RL9]
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         plane_choice_q <= RESET_REG[1:0];
      end else if (data_wr && index_q == IDX_PLANE_CHOICE) begin // [RL2]
         plane_choice_q <= io_wdata[CHOICE_LSB +: CHOICE_W]; // [RL10]
      end
   end

   // Register readback
   always_comb begin
      io_rdata_d = READ_UNMAPPED;
      if (port_hit(io_addr, IO_INDEX_PORT)) begin
         io_rdata_d = {4'h0, index_q}; // [RL1]
      end else if (port_hit(io_addr, IO_DATA_PORT)) begin
         case (index_q) // [RL16]
            IDX_FILL_VALUE: io_rdata_d = {4'h0, fill_value_q};
            IDX_FILL_ENABLE: io_rdata_d = {4'h0, fill_enable_q};
            IDX_MATCH_VALUE: io_rdata_d = {4'h0, match_value_q};
            IDX_COMBINE_SHIFT: io_rdata_d = {3'h0, combine_shift_q};
            IDX_PLANE_CHOICE: io_rdata_d = {6'h00, plane_choice_q};
            default: io_rdata_d = READ_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         io_rdata_q <= 8'h00;
      end else if (io_rd) begin
         io_rdata_q <= io_rdata_d;
      end
   end

   // Read latches
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         latch_q <= '0;
      end else if (mem_rd) begin
         latch_q <= mem_rdata; // [RL14]
      end
   end

   // Host read path
   always_comb begin
      for (int b = 0; b < 8; b++) begin
         match_bits[b] = 1'b1;
         for (int p = 0; p < 4; p++) begin
            match_bits[b] = match_bits[b] & ~(mem_rdata[p][b] ^ match_value_q[p]); // [RL5]
         end
      end
      read_plane = odd_even ? {plane_choice_q[1], mem_a0} : plane_choice_q; // [RL12]
      host_rdata_d = read_type ? match_bits : mem_rdata[read_plane]; // [RL13] [RL11]
   end

   // Read result
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         host_rdata_q <= 8'h00;
      end else if (mem_rd) begin
         host_rdata_q <= host_rdata_d;
      end
   end

   // Read valid strobe
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         host_rvalid_q <= 1'b0;
      end else begin
         host_rvalid_q <= mem_rd;
      end
   end

   // Write shaping
   assign sh.fill_value = fill_value_q;
   assign sh.fill_enable = fill_enable_q;
   assign sh.rot_count = combine_shift_q[ROT_LSB +: ROT_W]; // [RL9]
   assign sh.func = combine_fn_t'(combine_shift_q[FUNC_LSB +: FUNC_W]); // [RL6]
   assign sh.mode = write_mode_t'(write_mode); // [RL15]
   assign sh.host_data = mem_wdata;
   assign sh.latches = latch_q;

   plane_write_shaper u_shaper (
      .sh(sh.shaper)
   );

   // Shaped write data
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         plane_wdata_q <= '0;
      end else if (mem_wr) begin
         plane_wdata_q <= sh.shaped;
      end
   end

   // Write strobe
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         plane_we_q <= 1'b0;
      end else begin
         plane_we_q <= mem_wr;
      end
   end

   assign io_rdata = io_rdata_q;
   assign plane_wdata = plane_wdata_q;
   assign plane_we = plane_we_q;
   assign host_rdata = host_rdata_q;
   assign host_rvalid = host_rvalid_q;
endmodule
`default_nettype wire

// >>> plane_path_pkg.sv
package plane_path_pkg;
   localparam logic [15:0] IO_INDEX_PORT = 16'h03CE;
   localparam logic [15:0] IO_DATA_PORT = 16'h03CF;
   localparam logic [3:0] IDX_FILL_VALUE = 4'h0;
   localparam logic [3:0] IDX_FILL_ENABLE = 4'h1;
   localparam logic [3:0] IDX_MATCH_VALUE = 4'h2;
   localparam logic [3:0] IDX_COMBINE_SHIFT = 4'h3;
   localparam logic [3:0] IDX_PLANE_CHOICE = 4'h4;
   localparam int INDEX_LSB = 0;
   localparam int INDEX_W = 4;
   localparam int PLANE_FIELD_LSB = 0;
   localparam int PLANE_FIELD_W = 4;
   localparam int ROT_LSB = 0;
   localparam int ROT_W = 3;
   localparam int FUNC_LSB = 3;
   localparam int FUNC_W = 2;
   localparam int CHOICE_LSB = 0;
   localparam int CHOICE_W = 2;
   localparam logic [7:0] RESET_INDEX = 8'h00;
   localparam logic [7:0] RESET_REG = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam int READ_LATENCY = 1;
   localparam int WRITE_LATENCY = 1;

   typedef logic [3:0][7:0] plane_bytes_t;

   typedef enum logic [1:0] {
      WM_ROTATE_FILL = 2'b00,
      WM_LATCH_COPY = 2'b01,
      WM_BIT_SPREAD = 2'b10,
      WM_FILL_ALL = 2'b11
   } write_mode_t;

   typedef enum logic [1:0] {
      FN_PASS = 2'b00,
      FN_AND = 2'b01,
      FN_OR = 2'b10,
      FN_XOR = 2'b11
   } combine_fn_t;

   function automatic logic [7:0] spread8(input logic b);
      spread8 = {8{b}};
   endfunction
endpackage

// >>> plane_shape_if.sv
`timescale 1ns/1ps
`default_nettype none
interface plane_shape_if;
   import plane_path_pkg::*;
   logic [3:0] fill_value;
   logic [3:0] fill_enable;
   logic [2:0] rot_count;
   combine_fn_t func;
   write_mode_t mode;
   logic [7:0] host_data;
   plane_bytes_t latches;
   plane_bytes_t shaped;
   modport regs (output fill_value, fill_enable, rot_count, func, mode, host_data, latches, input shaped);
   modport shaper (input fill_value, fill_enable, rot_count, func, mode, host_data, latches, output shaped);
endinterface
`default_nettype wire

// >>> plane_write_shaper.sv
`timescale 1ns/1ps
`default_nettype none
module plane_write_shaper (
   plane_shape_if.shaper sh
);
   import plane_path_pkg::*;

   logic [7:0] rotated;
   logic [15:0] doubled;

   // Right rotation of host data
   always_comb begin
      doubled = {sh.host_data, sh.host_data};
      rotated = doubled[sh.rot_count +: 8]; // [RL9]
   end

   always_comb begin
      logic [7:0] src;
      src = 8'h00;
      sh.shaped = '0;
      for (int p = 0; p < 4; p++) begin
         case (sh.mode)
            WM_ROTATE_FILL: begin
               src = sh.fill_enable[p] ? spread8(sh.fill_value[p]) : rotated; // [RL3] [RL4] [RL15]
            end
            WM_BIT_SPREAD: begin
               src = spread8(sh.host_data[p]);
            end
            WM_FILL_ALL: begin
               src = spread8(sh.fill_value[p]);
            end
            default: begin
               src = sh.latches[p];
            end
         endcase
         if (sh.mode == WM_LATCH_COPY) begin
            sh.shaped[p] = sh.latches[p]; // [RL8]
         end else begin
            // Combine follows rotation
            case (sh.func) // [RL6] [RL7]
               FN_AND: sh.shaped[p] = src & sh.latches[p];
               FN_OR: sh.shaped[p] = src | sh.latches[p];
               FN_XOR: sh.shaped[p] = src ^ sh.latches[p];
               default: sh.shaped[p] = src;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// >>> plane_datapath_chk.sv
`timescale 1ns/1ps
`default_nettype none
module plane_datapath_chk (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [15:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic [1:0] write_mode,
   input wire logic read_type,
   input wire logic odd_even,
   input wire logic mem_wr,
   input wire logic mem_rd,
   input wire plane_path_pkg::plane_bytes_t mem_rdata,
   input wire plane_path_pkg::plane_bytes_t plane_wdata,
   input wire logic plane_we,
   input wire logic [7:0] host_rdata,
   input wire logic host_rvalid
);
   import plane_path_pkg::*;
   logic [7:0] idx_q;
   logic [7:0] regs_q [5];
   plane_bytes_t lat_q;
   logic [7:0] cmp, exp_io, sel;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         idx_q <= 8'h00;
         regs_q <= '{default: 8'h00};
      end else if (io_wr && io_addr == IO_INDEX_PORT) begin
         idx_q <= {4'h0, io_wdata[3:0]};
      end else if (io_wr && io_addr == IO_DATA_PORT && idx_q < 8'h05) begin
         regs_q[idx_q[2:0]] <= io_wdata & (idx_q == 8'h03 ? 8'h1F : idx_q == 8'h04 ? 8'h03 : 8'h0F);
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) lat_q <= '0;
      else if (mem_rd) lat_q <= mem_rdata;
   end
   always_comb begin
      cmp = 8'hFF;
      for (int p = 0; p < 4; p++) cmp &= ~(mem_rdata[p] ^ {8{regs_q[2][p]}});
      exp_io = io_addr == IO_INDEX_PORT ? idx_q : idx_q < 8'h05 ? regs_q[idx_q[2:0]] : 8'h00;
      sel = mem_rdata[regs_q[4][1:0]];
   end
   sequence wr_s; mem_wr; endsequence
   sequence copy_s; mem_wr && write_mode == 2'b01; endsequence
   sequence io_rd_s; io_rd && (io_addr == IO_INDEX_PORT || io_addr == IO_DATA_PORT); endsequence
   we_follows_a: assert property (wr_s |=> plane_we) else $error("write strobe missing");
   we_spurious_a: assert property (!mem_wr |=> !plane_we) else $error("stray write strobe");
   rvalid_a: assert property (mem_rd |=> host_rvalid) else $error("read valid missing");
   latch_copy_a: assert property (copy_s |=> plane_wdata == $past(lat_q)) else $error("latch copy altered");
   cmp_read_a: assert property (mem_rd && read_type |=> host_rdata == $past(cmp)) else $error("compare bad");
   plane_read_a: assert property (mem_rd && !read_type && !odd_even |=> host_rdata == $past(sel))
      else $error("plane read bad");
   io_read_a: assert property (io_rd_s |=> io_rdata == $past(exp_io)) else $error("port read bad");
   io_hold_a: assert property (!io_rd |=> $stable(io_rdata)) else $error("port data moved");
endmodule
bind plane_datapath plane_datapath_chk chk_u (.mclk, .rst_n, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
   .write_mode, .read_type, .odd_even, .mem_wr, .mem_rd, .mem_rdata, .plane_wdata, .plane_we, .host_rdata,
   .host_rvalid);
`default_nettype wire

// >>> host_cpu.sv
`timescale 1ns/1ps
`default_nettype none
module host_cpu (
   input wire logic mclk,
   output logic [15:0] io_addr,
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   output logic mem_rd,
   output plane_path_pkg::plane_bytes_t mem_rdata,
   input wire plane_path_pkg::plane_bytes_t plane_wdata,
   input wire logic [7:0] host_rdata
);
   import plane_path_pkg::*;
   initial begin
      {io_addr, io_wr, io_rd, io_wdata, mem_wr, mem_wdata, mem_rd} = '0;
      mem_rdata = '0;
   end
   task automatic io_write(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      {io_wr, io_addr, io_wdata} <= {1'b1, a, d};
      @(posedge mclk);
      {io_wr, io_wdata} <= {1'b0, ~d};
   endtask
   task automatic io_read(input logic [15:0] a, output logic [7:0] d);
      @(posedge mclk);
      {io_rd, io_addr} <= {1'b1, a};
      @(posedge mclk);
      io_rd <= 1'b0;
      #1 d = io_rdata;
   endtask
   task automatic reg_wr(input logic [3:0] i, input logic [7:0] d);
      io_write(IO_INDEX_PORT, {4'h0, i});
      io_write(IO_DATA_PORT, d);
   endtask
   task automatic reg_rd(input logic [3:0] i, output logic [7:0] d);
      io_write(IO_INDEX_PORT, {4'h0, i});
      io_read(IO_DATA_PORT, d);
   endtask
   task automatic mem_read(input plane_bytes_t m, output logic [7:0] r);
      @(posedge mclk);
      {mem_rd, mem_rdata} <= {1'b1, m};
      @(posedge mclk);
      {mem_rd, mem_rdata} <= {1'b0, ~m};
      #1 r = host_rdata;
   endtask
   task automatic mem_write(input logic [7:0] d, output plane_bytes_t w);
      @(posedge mclk);
      {mem_wr, mem_wdata} <= {1'b1, d};
      @(posedge mclk);
      {mem_wr, mem_wdata} <= {1'b0, ~d};
      #1 w = plane_wdata;
   endtask
endmodule
`default_nettype wire

// >>> plane_datapath_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define chk(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module plane_datapath_tb_top;
   import plane_path_pkg::*;
   logic mclk = 1'b0;
   logic rst_n, io_wr, io_rd, read_type, odd_even, mem_wr, mem_rd, mem_a0, plane_we, host_rvalid;
   logic [15:0] io_addr;
   logic [7:0] io_wdata, io_rdata, mem_wdata, host_rdata, r, e;
   logic [1:0] write_mode;
   plane_bytes_t mem_rdata, plane_wdata, w;
   plane_bytes_t lat = {8'h00, 8'hFF, 8'h3C, 8'hF0};
   logic [7:0] mask [5] = '{8'h0F, 8'h0F, 8'h0F, 8'h1F, 8'h03};
   int n_errors = 0;
   int checked = 0;
   always #10 mclk = ~mclk;
   plane_datapath dut_u (.mclk, .rst_n, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .write_mode, .read_type,
      .odd_even, .mem_wr, .mem_wdata, .mem_rd, .mem_a0, .mem_rdata, .plane_wdata, .plane_we, .host_rdata, .host_rvalid);
   host_cpu host_u (.mclk, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .mem_wr, .mem_wdata, .mem_rd, .mem_rdata,
      .plane_wdata, .host_rdata);
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge mclk);
      n_errors++;
      stop_test();
   end
   initial begin
      {rst_n, write_mode, read_type, odd_even, mem_a0} = '0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         host_u.reg_rd(i[3:0], r);
         `chk("reset", 8'h00, r)
         host_u.reg_wr(i[3:0], 8'hFF);
         host_u.reg_rd(i[3:0], r);
         `chk("regrw", mask[i], r)
      end
      host_u.io_write(IO_INDEX_PORT, 8'hF7);
      host_u.io_write(IO_DATA_PORT, 8'hFF);
      host_u.io_read(IO_INDEX_PORT, r);
      `chk("index", 8'h07, r)
      host_u.io_read(IO_DATA_PORT, r);
      `chk("unmapped", 8'h00, r)
      for (int c = 0; c < 4; c++) begin
         host_u.reg_wr(4'h4, c[7:0]);
         host_u.mem_read(lat, r);
         `chk("plane", lat[c], r)
      end
      @(posedge mclk);
      odd_even <= 1'b1;
      host_u.mem_read(lat, r);
      `chk("oddeven", lat[2], r)
      host_u.reg_wr(4'h4, 8'h00);
      @(posedge mclk);
      mem_a0 <= 1'b1;
      host_u.mem_read(lat, r);
      `chk("oddeven", lat[1], r)
      host_u.reg_wr(4'h2, 8'h05);
      @(posedge mclk);
      read_type <= 1'b1;
      for (int c = 0; c < 4; c += 3) begin
         host_u.reg_wr(4'h4, c[7:0]);
         host_u.mem_read(lat, r);
         `chk("compare", 8'hC0, r)
         `chk("rvalid", 1'b1, host_rvalid)
      end
      host_u.mem_read(~lat, r);
      `chk("compare", 8'h00, r)
      @(posedge mclk);
      write_mode <= 2'b01;
      host_u.mem_write(8'h12, w);
      `chk("latchcopy", ~lat, w)
      host_u.mem_read(lat, r);
      `chk("compare", 8'hC0, r)
      host_u.reg_wr(4'h0, 8'h05);
      host_u.reg_wr(4'h1, 8'h0C);
      @(posedge mclk);
      write_mode <= 2'b00;
      for (int f = 0; f < 4; f++) begin
         host_u.reg_wr(4'h3, {3'b000, f[1:0], 3'b011});
         host_u.mem_write(8'h96, w);
         `chk("we", 1'b1, plane_we)
         for (int p = 0; p < 4; p++) begin
            e = p == 2 ? 8'hFF : p == 3 ? 8'h00 : 8'hD2;
            e = f == 1 ? e & lat[p] : f == 2 ? e | lat[p] : f == 3 ? e ^ lat[p] : e;
            `chk("mode0", e, w[p])
         end
      end
      for (int m = 2; m < 4; m++) begin
         @(posedge mclk);
         write_mode <= m[1:0];
         host_u.mem_write(8'h96, w);
         for (int p = 0; p < 4; p++) begin
            e = {8{m == 2 ? (p == 1 || p == 2) : (p == 0 || p == 2)}} ^ lat[p];
            `chk("spreadfill", e, w[p])
         end
      end
      stop_test();
   end
endmodule
`undef chk
`default_nettype wire
